/* logic/button_postproc_consts.vh */
// Purpose: constants for the button post-processing block
// Assumes: byte-wide register port, addresses as listed below
// Notes: per-channel fields packed low channel first
`ifndef BUTTON_POSTPROC_CONSTS_VH
`define BUTTON_POSTPROC_CONSTS_VH

`define ADDR_STATUS 8'h00
`define ADDR_INT_POL 8'h11
`define ADDR_LP_STEP 8'h13
`define ADDR_NP_STEP 8'h15
`define ADDR_PAUSE_MAX 8'h16
`define ADDR_THRESHOLD_HYSTERESIS 8'h18
`define ADDR_TWIST 8'h19
`define ADDR_COMMON_DEFORM 8'h1A
`define ADDR_SCALER 8'h1E
`define ADDR_FAST_TRACK_CH0 8'h25
`define ADDR_FTF12 8'h28
`define ADDR_FAST_TRACK_CH3 8'h2B

`define RST_THRESHOLD_HYSTERESIS 8'h20
`define RST_ZERO 8'h00

`define ST_ERROR_BIT 0
`define ST_READY_BIT 1
`define ST_PRESSED_BIT 2
`define ST_OUT_BIT 3

`define TWIST_EN_BIT 7
`define NOMINAL_THR 25'h0000080
`define NP_STEP_DEN 12'h048
`define LP_STEP_DEN 12'h009
`define CONT_STEP_NUM 12'h008

`endif

/* logic/button_postproc.v */
// Purpose: per-channel button detection, baseline tracking, group filters, pins
// Assumes: i_scan_done pulses once at each sampling window end with counts valid
// Notes: register port addresses are bytes; reads return on the next edge
`timescale 1ns/100ps
`default_nettype none
`include "button_postproc_consts.vh"

module button_postproc (
    input wire i_mclk,
    input wire i_nrst,
    input wire i_scan_done,
    input wire [23:0] i_count_ch0,
    input wire [23:0] i_count_ch1,
    input wire [23:0] i_count_ch2,
    input wire [23:0] i_count_ch3,
    input wire i_power_mode_pin,
    input wire i_raw_mode,
    input wire i_continuous_sampling_bit,
    input wire i_error_event,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [7:0] o_reg_rdata,
    output wire [3:0] o_channel_press_pin,
    output reg o_interrupt_pin
);

    reg [7:0] int_pol_reg;
    reg [7:0] lp_step_reg;
    reg [7:0] np_step_reg;
    reg [7:0] pause_max_reg;
    reg [7:0] threshold_hysteresis_reg;
    reg [7:0] twist_reg;
    reg [7:0] common_deform_reg;
    reg [7:0] scaler_reg;
    reg [7:0] fast_track_ch0_reg;
    reg [7:0] ftf12_reg;
    reg [7:0] fast_track_ch3_reg;
    reg err_flag_reg;
    reg ready_flag_reg;
    reg out_flag_reg;
    reg init_reg;
    reg [3:0] pressed_reg;
    reg [3:0] pressed_next;

    wire [95:0] counts;
    wire [7:0] ftf_all;
    wire low_power;
    wire [3:0] step_index;
    wire [11:0] step_den;
    wire [24:0] on_thr;
    wire [24:0] off_thr;
    wire [24:0] twist_thr;
    wire [3:0] is_neg;
    wire [3:0] over_on;
    wire [3:0] over_off;
    wire [24:0] sig_w [0:3];
    wire [24:0] eff_w [0:3];
    wire [99:0] sig_all;
    wire status_rd;
    wire any_pressed;
    wire int_active;

    assign counts = {i_count_ch3, i_count_ch2, i_count_ch1, i_count_ch0};
    assign ftf_all = {fast_track_ch3_reg[1:0], ftf12_reg[3:2], ftf12_reg[1:0], fast_track_ch0_reg[1:0]};
    assign low_power = ~i_power_mode_pin;
    assign step_index = low_power ? {1'b0, lp_step_reg[2:0]} : {1'b0, np_step_reg[2:0]};
    assign step_den = low_power ? `LP_STEP_DEN : `NP_STEP_DEN;
    assign on_thr = `NOMINAL_THR + {17'h00000, threshold_hysteresis_reg};
    assign off_thr = `NOMINAL_THR - {17'h00000, threshold_hysteresis_reg};
    assign twist_thr = 25'h0000000 - {18'h00000, twist_reg[6:0]};
    assign status_rd = i_reg_rd && (i_reg_addr == `ADDR_STATUS);

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : chan
            reg [23:0] baseline_reg;
            reg [11:0] acc_reg;
            wire [23:0] scaled;
            wire [24:0] sig;
            wire [23:0] mag;
            wire [11:0] base_step;
            wire [11:0] num;
            wire [11:0] total;
            wire [11:0] moves;
            wire [23:0] move;
            wire frozen;
            wire track;

            assign scaled = counts[g*24 +: 24] >> scaler_reg[g*2 +: 2];
            assign sig = {1'b0, scaled} - {1'b0, baseline_reg};
            assign sig_w[g] = sig;
            assign is_neg[g] = sig[24];
            assign mag = sig[24] ? (baseline_reg - scaled) : sig[23:0];
            assign base_step = i_continuous_sampling_bit && !low_power ? `CONT_STEP_NUM
                               : (12'h001 << step_index);
            assign num = !sig[24] ? base_step
                         : (ftf_all[g*2 +: 2] == 2'b00) ? base_step
                         : (ftf_all[g*2 +: 2] == 2'b01) ? (base_step << 2)
                         : (ftf_all[g*2 +: 2] == 2'b10) ? (base_step << 3)
                         : (base_step << 4);
            assign total = acc_reg + num;
            assign moves = total / step_den;
            assign move = ({12'h000, moves} > mag) ? mag : {12'h000, moves};
            assign frozen = pause_max_reg[g] && pressed_reg[g];
            assign track = !i_raw_mode && !frozen;

            assign over_on[g] = ($signed(eff_w[g]) >= $signed(on_thr));
            assign over_off[g] = ($signed(eff_w[g]) > $signed(off_thr));

            always @(posedge i_mclk or negedge i_nrst) begin
                if (!i_nrst) begin
                    baseline_reg <= 24'h000000;
                    acc_reg <= 12'h000;
                end else if (i_scan_done) begin
                    if (!init_reg) begin
                        baseline_reg <= scaled;
                        acc_reg <= 12'h000;
                    end else if (track) begin
                        acc_reg <= total - ((moves * step_den) & 12'hFFF);
                        if (sig[24]) begin
                            baseline_reg <= baseline_reg - move;
                        end else begin
                            baseline_reg <= baseline_reg + move;
                        end
                    end
                end
            end

            assign o_channel_press_pin[g] = pressed_reg[g];
        end
    endgenerate

    assign sig_all = {sig_w[3], sig_w[2], sig_w[1], sig_w[0]};

    // deform group: a member loses half of the strongest other member's rise
    // all signals come in as arguments so the assign wakes on any member's change
    function [24:0] deform_eff;
        input [1:0] ch;
        input [99:0] sigs;
        input [3:0] grp;
        integer k;
        reg [24:0] best;
        begin
            best = 25'h0000000;
            for (k = 0; k < 4; k = k + 1) begin
                if (k != ch && grp[k] && !sigs[k * 25 + 24] && sigs[k * 25 +: 25] > best) begin
                    best = sigs[k * 25 +: 25];
                end
            end
            deform_eff = sigs[ch * 25 +: 25] - {1'b0, best[24:1]};
        end
    endfunction

    generate
        for (g = 0; g < 4; g = g + 1) begin : eff
            assign eff_w[g] = common_deform_reg[4 + g] ? deform_eff(g, sig_all, common_deform_reg[7:4]) : sig_w[g];
        end
    endgenerate

    // group filters and hysteresis
    always @* begin : detect
        integer i;
        integer j;
        reg twist_block;
        reg [2:0] common_cnt;
        reg [3:0] cand;
        i = 0;
        j = 0;
        twist_block = 1'b0;
        common_cnt = 3'h0;
        cand = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            if (twist_reg[`TWIST_EN_BIT] && is_neg[i] && $signed(sig_w[i]) < $signed(twist_thr)) begin
                twist_block = 1'b1;
            end
            if (common_deform_reg[i] && over_on[i]) begin
                common_cnt = common_cnt + 3'h1;
            end
        end
        for (i = 0; i < 4; i = i + 1) begin
            cand[i] = over_on[i] && !twist_block;
            if (common_deform_reg[i] && common_cnt > 3'h1) begin
                cand[i] = 1'b0;
            end
        end
        for (i = 0; i < 4; i = i + 1) begin
            if (pause_max_reg[4 + i]) begin
                for (j = 0; j < 4; j = j + 1) begin
                    if (j != i && pause_max_reg[4 + j] && (over_on[j] || pressed_reg[j])
                        && ($signed(eff_w[j]) > $signed(eff_w[i])
                        || ($signed(eff_w[j]) == $signed(eff_w[i]) && j < i))) begin
                        cand[i] = 1'b0;
                    end
                end
            end
        end
        for (i = 0; i < 4; i = i + 1) begin
            if (i_raw_mode || !init_reg) begin
                pressed_next[i] = 1'b0;
            end else if (pressed_reg[i]) begin
                pressed_next[i] = over_off[i];
            end else begin
                pressed_next[i] = cand[i];
            end
        end
    end

    assign any_pressed = |pressed_reg;
    assign int_active = any_pressed || err_flag_reg || (i_raw_mode && ready_flag_reg);

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pressed_reg <= 4'h0;
            init_reg <= 1'b0;
        end else if (i_scan_done) begin
            pressed_reg <= pressed_next;
            init_reg <= 1'b1;
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            err_flag_reg <= 1'b0;
            ready_flag_reg <= 1'b0;
            out_flag_reg <= 1'b0;
        end else begin
            if (i_error_event) begin
                err_flag_reg <= 1'b1;
            end else if (status_rd) begin
                err_flag_reg <= 1'b0;
            end
            if (i_scan_done) begin
                ready_flag_reg <= 1'b1;
            end else if (status_rd) begin
                ready_flag_reg <= 1'b0;
            end
            if (i_scan_done && (|pressed_next) && !any_pressed) begin
                out_flag_reg <= 1'b1;
            end else if (status_rd) begin
                out_flag_reg <= 1'b0;
            end
        end
    end

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_interrupt_pin <= 1'b1;
        end else begin
            o_interrupt_pin <= int_pol_reg[0] ? int_active : !int_active;
        end
    end

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            int_pol_reg <= `RST_ZERO;
            lp_step_reg <= `RST_ZERO;
            np_step_reg <= `RST_ZERO;
            pause_max_reg <= `RST_ZERO;
            threshold_hysteresis_reg <= `RST_THRESHOLD_HYSTERESIS;
            twist_reg <= `RST_ZERO;
            common_deform_reg <= `RST_ZERO;
            scaler_reg <= `RST_ZERO;
            fast_track_ch0_reg <= `RST_ZERO;
            ftf12_reg <= `RST_ZERO;
            fast_track_ch3_reg <= `RST_ZERO;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `ADDR_INT_POL: int_pol_reg <= i_reg_wdata;
                `ADDR_LP_STEP: lp_step_reg <= i_reg_wdata;
                `ADDR_NP_STEP: np_step_reg <= i_reg_wdata;
                `ADDR_PAUSE_MAX: pause_max_reg <= i_reg_wdata;
                `ADDR_THRESHOLD_HYSTERESIS: threshold_hysteresis_reg <= i_reg_wdata;
                `ADDR_TWIST: twist_reg <= i_reg_wdata;
                `ADDR_COMMON_DEFORM: common_deform_reg <= i_reg_wdata;
                `ADDR_SCALER: scaler_reg <= i_reg_wdata;
                `ADDR_FAST_TRACK_CH0: fast_track_ch0_reg <= i_reg_wdata;
                `ADDR_FTF12: ftf12_reg <= i_reg_wdata;
                `ADDR_FAST_TRACK_CH3: fast_track_ch3_reg <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `ADDR_STATUS: o_reg_rdata <= {4'h0, out_flag_reg, any_pressed, ready_flag_reg, err_flag_reg};
                `ADDR_INT_POL: o_reg_rdata <= int_pol_reg;
                `ADDR_LP_STEP: o_reg_rdata <= lp_step_reg;
                `ADDR_NP_STEP: o_reg_rdata <= np_step_reg;
                `ADDR_PAUSE_MAX: o_reg_rdata <= pause_max_reg;
                `ADDR_THRESHOLD_HYSTERESIS: o_reg_rdata <= threshold_hysteresis_reg;
                `ADDR_TWIST: o_reg_rdata <= twist_reg;
                `ADDR_COMMON_DEFORM: o_reg_rdata <= common_deform_reg;
                `ADDR_SCALER: o_reg_rdata <= scaler_reg;
                `ADDR_FAST_TRACK_CH0: o_reg_rdata <= fast_track_ch0_reg;
                `ADDR_FTF12: o_reg_rdata <= ftf12_reg;
                `ADDR_FAST_TRACK_CH3: o_reg_rdata <= fast_track_ch3_reg;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule // button_postproc
`default_nettype wire

/* sim/postproc_monitor.sv */
// Purpose: port checker for button post-processing
// Assumes: pins and interrupt registered, polarity bit0 of 0x11
// Notes: shadows polarity and hysteresis writes
`timescale 1ns/100ps
`default_nettype none
module postproc_monitor (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_scan_done,
    input wire logic i_raw_mode,
    input wire logic i_error_event,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [3:0] o_channel_press_pin,
    input wire logic o_interrupt_pin
);
    logic pol_reg;
    logic [7:0] threshold_hysteresis_reg;
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pol_reg <= 1'b0;
            threshold_hysteresis_reg <= 8'h20;
        end else if (i_reg_wr) begin
            if (i_reg_addr == 8'h11) pol_reg <= i_reg_wdata[0];
            if (i_reg_addr == 8'h18) threshold_hysteresis_reg <= i_reg_wdata;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    a_pins_on_scan: assert property (!$stable(o_channel_press_pin) |-> $past(i_scan_done))
        else $error("press pins moved without scan");
    a_press_int: assert property ($past(|o_channel_press_pin) && !$past(i_raw_mode) && $stable(pol_reg)
        |-> o_interrupt_pin == pol_reg) else $error("interrupt inactive while pressed");
    a_error_int: assert property (i_error_event |-> ##[1:2] (o_interrupt_pin == pol_reg))
        else $error("error did not raise interrupt");
    a_raw_pins: assert property ($past(i_raw_mode) && $past(i_scan_done) |-> o_channel_press_pin == 4'h0)
        else $error("press pin set in raw mode");
    a_raw_ready: assert property (i_raw_mode && i_scan_done |-> ##[1:3] (o_interrupt_pin == pol_reg))
        else $error("no data ready interrupt");
    a_rdata_hold: assert property (!$stable(o_reg_rdata) |-> $past(i_reg_rd))
        else $error("read data moved without read");
    a_threshold_hysteresis_read: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 8'h18 |-> o_reg_rdata == $past(threshold_hysteresis_reg))
        else $error("hysteresis readback wrong");
    a_pressed_live: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 8'h00 && !$past(i_scan_done)
        && !$past(i_raw_mode) |-> o_reg_rdata[2] == $past(|o_channel_press_pin)) else $error("pressed bit wrong");
    c_press: cover property ($rose(o_channel_press_pin[0]));
    c_raw_scan: cover property (i_raw_mode && i_scan_done);
    c_error: cover property (i_error_event);
endmodule // postproc_monitor
bind button_postproc postproc_monitor mon (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_scan_done(i_scan_done),
    .i_raw_mode(i_raw_mode), .i_error_event(i_error_event), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_channel_press_pin(o_channel_press_pin), .o_interrupt_pin(o_interrupt_pin));
`default_nettype wire

/* sim/host_model.sv */
// Purpose: host side of the register port
// Assumes: strobes change at the falling edge
// Notes: write data inverted once released
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic i_mclk,
    input wire logic [7:0] i_reg_rdata,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    output logic o_reg_wr,
    output logic o_reg_rd
);
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
    end
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = 1'b1;
        @(negedge i_mclk);
        o_reg_wr = 1'b0;
        o_reg_wdata = ~d;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_mclk);
        o_reg_addr = a;
        o_reg_rd = 1'b1;
        @(negedge i_mclk);
        o_reg_rd = 1'b0;
        d = i_reg_rdata;
    endtask
endmodule // host_model
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: self-checking bench for button post-processing
// Assumes: 50 MHz clock, inputs driven at falling edge
// Notes: drift cases restart the block and count scans from a known remainder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_mclk, i_nrst, scan, pmode, raw, err, wr, rd, intr, cont;
    logic [23:0] cnt [4];
    logic [23:0] base, onv;
    logic [7:0] addr, wdata, rdata, rd_val, threshold_hysteresis;
    logic [3:0] pins;
    logic [7:0] regs [12] = '{8'h11, 8'h13, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1A, 8'h1E, 8'h25, 8'h28, 8'h2B, 8'h01};
    int err_total, check_count, cycles;
    button_postproc uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_scan_done(scan), .i_count_ch0(cnt[0]),
        .i_count_ch1(cnt[1]), .i_count_ch2(cnt[2]), .i_count_ch3(cnt[3]), .i_power_mode_pin(pmode),
        .i_raw_mode(raw), .i_continuous_sampling_bit(cont), .i_error_event(err), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .o_channel_press_pin(pins), .o_interrupt_pin(intr));
    host_model host (.i_mclk(i_mclk), .i_reg_rdata(rdata), .o_reg_addr(addr), .o_reg_wdata(wdata),
        .o_reg_wr(wr), .o_reg_rd(rd));
    function automatic logic [7:0] reg_reset(input logic [7:0] a);
        return (a == 8'h18) ? 8'h20 : 8'h00;
    endfunction
    function automatic logic [23:0] on_level(input logic [7:0] h);
        return 24'h000080 + {16'h0000, h};
    endfunction
    function automatic logic [23:0] off_level(input logic [7:0] h);
        return 24'h000080 - {16'h0000, h};
    endfunction
    // scans until the summed baseline moves reach the on/off gap
    function automatic int scans_held(input int step, input int den, input int acc0, input int drop);
        int n;
        n = 0;
        while ((acc0 + step * n) / den < drop) begin
            n++;
        end
        return n;
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic do_scan(input logic [23:0] o0, input logic [23:0] o1);
        @(negedge i_mclk);
        cnt[0] = base + o0;
        cnt[1] = base + o1;
        scan = 1'b1;
        @(negedge i_mclk);
        scan = 1'b0;
        @(negedge i_mclk);
    endtask
    task automatic restart(input logic pm);
        @(negedge i_mclk);
        i_nrst = 1'b0;
        raw = 1'b0;
        pmode = pm;
        base = 24'($urandom & 32'h000FFFFF) | 24'h100000;
        foreach (cnt[i]) cnt[i] = base;
        threshold_hysteresis = 8'h20;
        onv = on_level(threshold_hysteresis);
        repeat (2) @(negedge i_mclk);
        i_nrst = 1'b1;
        check(intr, 1'b1);
        check(pins, 4'h0);
    endtask
    // one step-0 scan before the index write leaves one unit of remainder
    task automatic track_case(input logic pm, input logic [7:0] sreg, input logic [2:0] idx, input int den);
        int n;
        restart(pm);
        host.reg_write(8'h1E, 8'h01);
        host.reg_write(8'h16, 8'h02);
        do_scan(24'h0, 24'h0);
        do_scan(2 * onv - 24'h2, onv - 24'h1);
        check(pins, 4'h0);
        host.reg_write(sreg, {5'h00, idx});
        raw = 1'b1;
        repeat (4) begin
            do_scan(2 * onv, onv);
            check(pins, 4'h0);
        end
        raw = 1'b0;
        n = scans_held(1 << idx, den, 1, onv - off_level(threshold_hysteresis));
        repeat (n) begin
            do_scan(2 * onv, onv);
            check(pins, 4'h3);
        end
        do_scan(2 * onv, onv);
        check(pins, 4'h2);
    endtask
    task automatic end_of_test();
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        i_nrst = 1'b0;
        scan = 1'b0;
        pmode = 1'b1;
        raw = 1'b0;
        err = 1'b0;
        cont = 1'b0;
        void'($urandom(36298));
        base = $urandom & 24'h0FFFFF;
        foreach (cnt[i]) cnt[i] = base;
        repeat (2) @(negedge i_mclk);
        i_nrst = 1'b1;
        foreach (regs[i]) begin
            host.reg_read(regs[i], rd_val);
            check(rd_val, reg_reset(regs[i]));
        end
        threshold_hysteresis = 8'h10 + ($urandom % 8'h50);
        host.reg_write(8'h18, threshold_hysteresis);
        host.reg_read(8'h18, rd_val);
        check(rd_val, threshold_hysteresis);
        do_scan(24'h0, 24'h0);
        do_scan(on_level(threshold_hysteresis) - 24'h1, 24'h0);
        check(pins, 4'h0);
        do_scan(on_level(threshold_hysteresis), 24'h0);
        check(pins, 4'h1);
        check(intr, 1'b0);
        host.reg_read(8'h00, rd_val);
        check(rd_val[3], 1'b1);
        host.reg_read(8'h00, rd_val);
        check(rd_val[3], 1'b0);
        do_scan(on_level(threshold_hysteresis), on_level(threshold_hysteresis));
        check(pins, 4'h3);
        do_scan(off_level(threshold_hysteresis), on_level(threshold_hysteresis));
        check(pins, 4'h2);
        check(intr, 1'b0);
        do_scan(24'h0, off_level(threshold_hysteresis) + 24'h1);
        check(pins, 4'h2);
        do_scan(24'h0, off_level(threshold_hysteresis));
        check(pins, 4'h0);
        host.reg_write(8'h11, 8'h01);
        @(negedge i_mclk);
        err = 1'b1;
        @(negedge i_mclk);
        err = 1'b0;
        repeat (2) @(negedge i_mclk);
        check(intr, 1'b1);
        host.reg_read(8'h00, rd_val);
        check(rd_val[0], 1'b1);
        raw = 1'b1;
        do_scan(on_level(threshold_hysteresis) + 24'h40, 24'h0);
        check(pins, 4'h0);
        @(negedge i_mclk);
        check(intr, 1'b1);
        track_case(1'b1, 8'h15, 3'h7, 72);
        track_case(1'b0, 8'h13, 3'h4, 9);
        restart(1'b1);
        do_scan(24'h0, 24'h0);
        host.reg_write(8'h16, 8'h30);
        do_scan(onv + 24'h8, onv);
        check(pins, 4'h1);
        do_scan(24'h0, 24'h0);
        host.reg_write(8'h16, 8'h00);
        host.reg_write(8'h1A, 8'h03);
        do_scan(onv, onv);
        check(pins, 4'h0);
        do_scan(onv, 24'h0);
        check(pins, 4'h1);
        do_scan(24'h0, 24'h0);
        host.reg_write(8'h1A, 8'h30);
        do_scan(onv + 24'h1E, 24'h40);
        check(pins, 4'h0);
        do_scan(onv + 24'h20, 24'h40);
        check(pins, 4'h1);
        do_scan(24'h0, 24'h0);
        host.reg_write(8'h1A, 8'h00);
        host.reg_write(8'h19, 8'h90);
        do_scan(onv, 24'hFFFFEF);
        check(pins, 4'h0);
        do_scan(onv, 24'hFFFFF0);
        check(pins, 4'h1);
        do_scan(24'h0, 24'h0);
        check(pins, 4'h0);
        host.reg_write(8'h19, 8'h00);
        host.reg_write(8'h15, 8'h07);
        host.reg_write(8'h25, 8'h03);
        cont = 1'b1;
        do_scan(24'hFFFF00, 24'h0);
        do_scan(onv - 24'h3, 24'h0);
        check(pins, 4'h0);
        cont = 1'b0;
        do_scan(24'hFFFF00, 24'h0);
        do_scan(onv - 24'h1C, 24'h0);
        check(pins, 4'h1);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
